// *** rtl/access_guard.sv ***
// memory translation and register access guard
`timescale 1ns/1ps
module access_guard (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // mode flags from the core
  input wire logic boot_flag,
  input wire logic test_flag,
  // cpu memory request
  input wire acc_pkg::mem_op_type cpu_op,
  input wire logic [17:0] cpu_vaddr,
  input wire logic [7:0] cpu_wdata,
  // physical memory side
  output acc_pkg::mem_op_type mem_op_q,
  output logic [17:0] mem_addr_q,
  output logic [7:0] mem_wdata_q,
  output logic fault_q,
  output logic busy_q,
  // register port
  input wire acc_pkg::sfr_req_type sfr,
  output logic [7:0] sfr_rdata_q,
  // registers outside this block
  output logic hw_rd_q,
  output logic hw_wr_q,
  output logic [7:0] hw_addr_q,
  output logic [7:0] hw_wdata_q,
  input wire logic [7:0] hw_rdata,
  // segment table fetch
  output logic tbl_rd_q,
  output logic [15:0] tbl_addr_q,
  input wire logic [acc_pkg::TBL_W-1:0] tbl_data
);
  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_ISSUE = 2'b01,
    LD_WAIT = 2'b10,
    LD_TAKE = 2'b11
  } ld_type;

  function automatic logic in_rng(input logic [17:0] a, input logic [17:0] lo,
      input logic [17:0] hi);
    return a >= lo && a <= hi;
  endfunction : in_rng

  function automatic acc_pkg::group_type sfr_grp(input logic [7:0] a);
    if (a[7]) return acc_pkg::GRP_HW;
    if (a[6]) return acc_pkg::GRP_TST;
    if (a[5:4] == 2'h3) return acc_pkg::GRP_OS;
    if (a[5:4] == 2'h2) return acc_pkg::GRP_FW;
    if (a[5:4] == 2'h0) return acc_pkg::GRP_CPU;
    if (a[3]) return acc_pkg::GRP_SYS;
    return acc_pkg::GRP_MMU;
  endfunction : sfr_grp

  acc_pkg::seg_type seg_q [acc_pkg::SEGS];
  acc_pkg::mode_type mode;
  acc_pkg::group_type grp;
  acc_pkg::seg_type seg;
  ld_type ld_q;
  logic [5:0] idx_q;
  logic [5:0] exec_seg_q;
  logic [7:0] psh_q, ptr_lo_q, ptr_hi_q, fw_lo_q, fw_hi_q;
  logic [7:0] xb_lo_q, xb_hi_q, xs_lo_q, xs_hi_q;
  logic [acc_pkg::SEGS-1:0] hit;
  logic [5:0] sel;
  logic found;
  logic [17:0] pa;
  logic any_op;
  logic reg_ok;
  logic mem_ok;
  logic t_rom, rom, nvm, mfr, os_nvm, ram, os_ram, xw;
  logic [17:0] xw_lo;
  logic [18:0] xw_end;
  logic hw_r, hw_w;
  logic s_ok;
  logic internal;
  logic [7:0] imux;
  logic start;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // test flag wins over boot, boot over the status bits
  always_comb
  begin
    if (test_flag)
      mode = acc_pkg::MODE_TEST;
    else if (boot_flag)
      mode = acc_pkg::MODE_BOOT;
    else if (psh_q[acc_pkg::PSH_OS_BIT])
      mode = acc_pkg::MODE_OS;
    else if (psh_q[acc_pkg::PSH_SYS_BIT])
      mode = acc_pkg::MODE_SYS;
    else
      mode = acc_pkg::MODE_USER;
  end

  // entry without any flag counts as empty
  for (genvar i = 0; i < acc_pkg::SEGS; i++)
  begin : g_seg
    assign hit[i] = (seg_q[i].r | seg_q[i].w | seg_q[i].x) &&
      cpu_vaddr >= seg_q[i].first && cpu_vaddr <= seg_q[i].last;
  end

  // lowest matching entry wins where segments overlap
  always_comb
  begin
    sel = '0;
    found = 1'b0;
    for (int i = acc_pkg::SEGS - 1; i >= 0; i--)
      if (hit[i])
      begin
        sel = 6'(i);
        found = 1'b1;
      end
  end

  assign seg = seg_q[sel];
  assign any_op = cpu_op.rd | cpu_op.wr | cpu_op.ex;
  assign pa = (mode == acc_pkg::MODE_USER) ? 18'(cpu_vaddr + seg.offset) : cpu_vaddr;
  assign xw_lo = 18'(acc_pkg::RAM_LO + {xb_hi_q, xb_lo_q});
  assign xw_end = 19'(xw_lo) + 19'({xs_hi_q, xs_lo_q});

  always_comb
  begin
    t_rom = in_rng(pa, acc_pkg::ROM_LO, acc_pkg::TROM_HI);
    rom = in_rng(pa, acc_pkg::ROM_LO, acc_pkg::ROM_HI);
    nvm = in_rng(pa, acc_pkg::NVM_LO, acc_pkg::NVM_HI);
    mfr = in_rng(pa, acc_pkg::MFR_LO, acc_pkg::NVM_HI);
    os_nvm = in_rng(pa, acc_pkg::OSNVM_LO, acc_pkg::NVM_HI) && !mfr;
    ram = in_rng(pa, acc_pkg::RAM_LO, acc_pkg::RAM_HI);
    os_ram = in_rng(pa, acc_pkg::OSRAM_LO, acc_pkg::RAM_HI);
    xw = ram && pa >= xw_lo && 19'(pa) < xw_end;
    unique case (mode)
      acc_pkg::MODE_BOOT:
        reg_ok = (t_rom && !cpu_op.wr) || os_nvm || (os_ram && !cpu_op.ex);
      acc_pkg::MODE_TEST:
        reg_ok = (rom && !cpu_op.wr) || nvm || (ram && !cpu_op.ex);
      acc_pkg::MODE_OS:
        reg_ok = os_nvm || ((os_ram || xw) && !cpu_op.ex);
      default:
        reg_ok = (rom && !t_rom && !cpu_op.wr) || (nvm && !os_nvm && !mfr) ||
          (ram && !os_ram && !cpu_op.ex);
    endcase
  end

  // user code also needs the matching entry's flag for this operation
  assign mem_ok = any_op && ld_q == LD_IDLE && reg_ok &&
    (mode != acc_pkg::MODE_USER || (found && (!cpu_op.rd || seg.r) &&
    (!cpu_op.wr || seg.w) && (!cpu_op.ex || seg.x)));

  // check and translate in the request cycle; strobe only when granted
  always_ff @(posedge ref_clk)
    if (rst)
    begin
      mem_op_q <= '0;
      mem_addr_q <= '0;
      mem_wdata_q <= '0;
      fault_q <= 1'b0;
    end
    else if (ce)
    begin
      mem_op_q <= mem_ok ? cpu_op : '0;
      mem_addr_q <= pa;
      mem_wdata_q <= cpu_wdata;
      fault_q <= any_op && !mem_ok;
    end

  always_ff @(posedge ref_clk)
    if (rst)
      exec_seg_q <= '0;
    else if (ce && mem_ok && cpu_op.ex && mode == acc_pkg::MODE_USER)
      exec_seg_q <= sel;

  always_ff @(posedge ref_clk)
    if (rst)
      busy_q <= 1'b0;
    else if (ce)
      busy_q <= start || (ld_q != LD_IDLE && !(ld_q == LD_TAKE && idx_q == acc_pkg::LAST_SEG));

  // register guard
  assign grp = sfr_grp(sfr.addr);
  assign hw_r = (mode == acc_pkg::MODE_USER) ? seg_q[exec_seg_q].hw_rd : fw_lo_q[sfr.addr[6:4]];
  assign hw_w = (mode == acc_pkg::MODE_USER) ? seg_q[exec_seg_q].hw_wr : fw_hi_q[sfr.addr[6:4]];

  always_comb
  begin
    unique case (grp)
      acc_pkg::GRP_CPU:
        s_ok = 1'b1;
      acc_pkg::GRP_MMU:
        s_ok = mode == acc_pkg::MODE_SYS;
      acc_pkg::GRP_SYS:
        s_ok = mode inside {acc_pkg::MODE_BOOT, acc_pkg::MODE_TEST, acc_pkg::MODE_SYS} ||
          (sfr.addr == acc_pkg::PSH && !sfr.wr);
      acc_pkg::GRP_FW:
        s_ok = mode inside {acc_pkg::MODE_BOOT, acc_pkg::MODE_TEST, acc_pkg::MODE_SYS} ||
          (mode == acc_pkg::MODE_OS && !sfr.wr);
      acc_pkg::GRP_OS:
        s_ok = mode inside {acc_pkg::MODE_BOOT, acc_pkg::MODE_TEST, acc_pkg::MODE_OS};
      acc_pkg::GRP_TST:
        s_ok = mode inside {acc_pkg::MODE_BOOT, acc_pkg::MODE_TEST};
      default:
        s_ok = mode inside {acc_pkg::MODE_BOOT, acc_pkg::MODE_TEST, acc_pkg::MODE_SYS} ||
          (mode inside {acc_pkg::MODE_USER, acc_pkg::MODE_OS} &&
          (sfr.wr ? hw_w : hw_r));
    endcase
    if (sfr.rd && sfr.addr == acc_pkg::SFR_NO_READ)
      s_ok = 1'b0;
    if (sfr.wr && sfr.addr == acc_pkg::SFR_READ_ONLY)
      s_ok = 1'b0;
  end

  assign internal = grp inside {acc_pkg::GRP_MMU, acc_pkg::GRP_SYS, acc_pkg::GRP_FW};

  always_comb
  begin
    unique case (sfr.addr)
      acc_pkg::PTR_LO: imux = ptr_lo_q;
      acc_pkg::PTR_HI: imux = ptr_hi_q;
      acc_pkg::PSH: imux = psh_q;
      acc_pkg::STAT: imux = {4'h0, busy_q, 3'(mode)};
      acc_pkg::FW_LO: imux = fw_lo_q;
      acc_pkg::FW_HI: imux = fw_hi_q;
      acc_pkg::XB_LO: imux = xb_lo_q;
      acc_pkg::XB_HI: imux = xb_hi_q;
      acc_pkg::XS_LO: imux = xs_lo_q;
      acc_pkg::XS_HI: imux = xs_hi_q;
      default: imux = 8'h00;
    endcase
  end

  // outside registers answer combinationally to the request address
  always_ff @(posedge ref_clk)
    if (rst)
      sfr_rdata_q <= 8'h00;
    else if (ce && sfr.rd)
      sfr_rdata_q <= !s_ok ? 8'h00 : (internal ? imux : hw_rdata);

  always_ff @(posedge ref_clk)
    if (rst)
    begin
      hw_rd_q <= 1'b0;
      hw_wr_q <= 1'b0;
      hw_addr_q <= 8'h00;
      hw_wdata_q <= 8'h00;
    end
    else if (ce)
    begin
      hw_rd_q <= sfr.rd && s_ok && !internal;
      hw_wr_q <= sfr.wr && s_ok && !internal;
      hw_addr_q <= sfr.addr;
      hw_wdata_q <= sfr.wdata;
    end

  always_ff @(posedge ref_clk)
    if (rst)
    begin
      psh_q <= acc_pkg::PSH_RST;
      ptr_lo_q <= acc_pkg::REG_RST;
      ptr_hi_q <= acc_pkg::REG_RST;
      fw_lo_q <= acc_pkg::REG_RST;
      fw_hi_q <= acc_pkg::REG_RST;
      xb_lo_q <= acc_pkg::REG_RST;
      xb_hi_q <= acc_pkg::REG_RST;
      xs_lo_q <= acc_pkg::REG_RST;
      xs_hi_q <= acc_pkg::REG_RST;
    end
    else if (ce && sfr.wr && s_ok)
      unique case (sfr.addr)
        acc_pkg::PTR_LO: ptr_lo_q <= sfr.wdata;
        acc_pkg::PTR_HI: ptr_hi_q <= sfr.wdata;
        acc_pkg::PSH: psh_q <= sfr.wdata;
        acc_pkg::FW_LO: fw_lo_q <= sfr.wdata;
        acc_pkg::FW_HI: fw_hi_q <= sfr.wdata;
        acc_pkg::XB_LO: xb_lo_q <= sfr.wdata;
        acc_pkg::XB_HI: xb_hi_q <= sfr.wdata;
        acc_pkg::XS_LO: xs_lo_q <= sfr.wdata;
        acc_pkg::XS_HI: xs_hi_q <= sfr.wdata;
        default: ;
      endcase

  // table walk; a write to PTR_HI restarts it from entry zero
  assign start = sfr.wr && s_ok && sfr.addr == acc_pkg::PTR_HI;

  always_ff @(posedge ref_clk)
    if (rst)
    begin
      ld_q <= LD_IDLE;
      idx_q <= '0;
      tbl_rd_q <= 1'b0;
      tbl_addr_q <= '0;
    end
    else if (ce)
    begin
      if (start)
      begin
        ld_q <= LD_ISSUE;
        idx_q <= '0;
        tbl_rd_q <= 1'b0;
      end
      else
        unique case (ld_q)
          LD_IDLE: tbl_rd_q <= 1'b0;
          LD_ISSUE:
          begin
            tbl_rd_q <= 1'b1;
            tbl_addr_q <= {ptr_hi_q, ptr_lo_q} + 16'(idx_q);
            ld_q <= LD_WAIT;
          end
          LD_WAIT:
          begin
            tbl_rd_q <= 1'b0;
            ld_q <= LD_TAKE;
          end
          LD_TAKE:
          begin
            idx_q <= 6'(idx_q + 6'h01);
            ld_q <= (idx_q == acc_pkg::LAST_SEG) ? LD_IDLE : LD_ISSUE;
          end
        endcase
    end

  // reset leaves every entry empty, so no access is granted in user mode
  always_ff @(posedge ref_clk)
    if (rst)
    begin
      for (int i = 0; i < acc_pkg::SEGS; i++)
        seg_q[i] <= '0;
    end
    else if (ce && ld_q == LD_TAKE && !start)
      seg_q[idx_q] <= acc_pkg::seg_type'(tbl_data[acc_pkg::SEG_BITS-1:0]);

  a_deny_no_strobe: assert property (ce && any_op && !mem_ok |=>
    mem_op_q == '0 && fault_q) else $error("denied access reached memory");
  a_user_translate: assert property (ce && mem_ok && mode == acc_pkg::MODE_USER |=>
    mem_addr_q == 18'($past(cpu_vaddr) + $past(seg.offset))) else $error("bad translation");
  a_unused_entry: assert property (found |-> seg.r || seg.w || seg.x)
    else $error("empty entry matched");
  a_mfr_region: assert property (ce && any_op && mfr && mode != acc_pkg::MODE_TEST
    |=> fault_q && mem_op_q == '0) else $error("reserved nvm reached");
  a_read_zero: assert property (ce && sfr.rd && !s_ok |=> sfr_rdata_q == 8'h00)
    else $error("denied read leaked data");
  a_write_drop: assert property (ce && sfr.wr && !s_ok |=> !hw_wr_q &&
    $stable(psh_q) && $stable(fw_lo_q) && $stable(fw_hi_q)) else $error("denied write took");
  a_ptr_sys_only: assert property (ce && sfr.wr && grp == acc_pkg::GRP_MMU &&
    mode != acc_pkg::MODE_SYS |=> $stable(ptr_lo_q) && $stable(ptr_hi_q))
    else $error("pointer changed outside system mode");
  a_test_grp_user: assert property (ce && sfr.rd && grp == acc_pkg::GRP_TST &&
    mode == acc_pkg::MODE_USER |=> sfr_rdata_q == 8'h00 && !hw_rd_q)
    else $error("user read a test register");
  a_boot_no_app: assert property (ce && cpu_op.wr && rom &&
    mode == acc_pkg::MODE_BOOT |=> !mem_op_q.wr) else $error("boot wrote rom");
  a_walk_addr: assert property (ce && ld_q == LD_ISSUE && !start |=> tbl_rd_q &&
    tbl_addr_q == 16'({$past(ptr_hi_q), $past(ptr_lo_q)} + 16'($past(idx_q))))
    else $error("bad table address");
  a_busy_block: assert property (ce && any_op && ld_q != LD_IDLE |=> fault_q)
    else $error("access granted during walk");
  c_user_grant: cover property (ce && mem_ok && mode == acc_pkg::MODE_USER);
  c_os_hw_deny: cover property (ce && sfr.rd && mode == acc_pkg::MODE_OS && grp ==
    acc_pkg::GRP_HW && !s_ok);
  c_walk_done: cover property (ld_q == LD_TAKE && idx_q == acc_pkg::LAST_SEG);
  c_xw_hit: cover property (ce && mem_ok && mode == acc_pkg::MODE_OS && xw);
endmodule : access_guard

// *** inc/acc_pkg.sv ***
// types, offsets and limits for the memory and register access guard
// How it works
// - mode from program status high plus boot and test flags, one of five.
// - segment entry holds r/w/x flags, first and last address, relocation offset.
// - segment entry also holds hardware register read and write rights.
// - an entry with no r/w/x flag set never matches.
// - any number of the 64 entries may be used; unused ones stay zero.
// - user mode cpu addresses are virtual and leave translated to physical; other modes pass them unchanged.
// - access is checked before the memory strobe; denied ones never strobe.
// - every register access outside the cpu group (0x00-0x0F) is checked in hardware against the current mode.
// - user mode hardware rights from executing segment, os mode from firewall.
// - a denied register read returns zero.
// - a denied register write is dropped and changes nothing.
// - boot mode: test rom rx, os nvm rwx, os ram rw.
// - test mode: whole rom rx, whole nvm rwx, whole ram rw.
// - top 128 bytes of nvm are reserved for the manufacturer.
// - read, write, execute and register read, write checked separately.
// - firewall sets os hardware rights; base and size open a ram window.
// - pointer registers locate the table; entries are fetched from there.
// - the policy covers every mode, memory and operation.
// - fixed registers may be unreadable or unwritable whatever the rights.
// - table pointer registers are refused outside system mode.
// - system mode: app rom rx, app nvm rwx, app ram rw.
package acc_pkg;
  localparam int SEGS = 64;
  localparam int TBL_W = 64;
  // physical map
  localparam logic [17:0] ROM_LO = 18'h00000;
  localparam logic [17:0] TROM_HI = 18'h01FFF;
  localparam logic [17:0] ROM_HI = 18'h0FFFF;
  localparam logic [17:0] NVM_LO = 18'h10000;
  localparam logic [17:0] OSNVM_LO = 18'h17000;
  localparam logic [17:0] MFR_LO = 18'h17F80;
  localparam logic [17:0] NVM_HI = 18'h17FFF;
  localparam logic [17:0] RAM_LO = 18'h18000;
  localparam logic [17:0] OSRAM_LO = 18'h18700;
  localparam logic [17:0] RAM_HI = 18'h187FF;
  // register offsets
  localparam logic [7:0] PTR_LO = 8'h10;
  localparam logic [7:0] PTR_HI = 8'h11;
  localparam logic [7:0] PSH = 8'h18;
  localparam logic [7:0] STAT = 8'h19;
  localparam logic [7:0] FW_LO = 8'h20;
  localparam logic [7:0] FW_HI = 8'h21;
  localparam logic [7:0] XB_LO = 8'h22;
  localparam logic [7:0] XB_HI = 8'h23;
  localparam logic [7:0] XS_LO = 8'h24;
  localparam logic [7:0] XS_HI = 8'h25;
  localparam logic [7:0] SFR_NO_READ = 8'hF8;
  localparam logic [7:0] SFR_READ_ONLY = 8'hF0;
  localparam int PSH_SYS_BIT = 0;
  localparam int PSH_OS_BIT = 1;
  localparam logic [7:0] PSH_RST = 8'h01;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [5:0] LAST_SEG = 6'h3F;
  typedef enum logic [2:0] {
    MODE_BOOT = 3'b000,
    MODE_TEST = 3'b001,
    MODE_OS = 3'b010,
    MODE_SYS = 3'b011,
    MODE_USER = 3'b100
  } mode_type;
  typedef enum logic [2:0] {
    GRP_CPU = 3'b000,
    GRP_MMU = 3'b001,
    GRP_SYS = 3'b010,
    GRP_FW = 3'b011,
    GRP_OS = 3'b100,
    GRP_TST = 3'b101,
    GRP_HW = 3'b110
  } group_type;
  typedef struct packed {
    logic r;
    logic w;
    logic x;
    logic hw_rd;
    logic hw_wr;
    logic [17:0] first;
    logic [17:0] last;
    logic [17:0] offset;
  } seg_type;
  localparam int SEG_BITS = $bits(seg_type);
  typedef struct packed {
    logic rd;
    logic wr;
    logic ex;
  } mem_op_type;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_type;
endpackage : acc_pkg

// *** test/hw_side_model.sv ***
// far side model: segment table memory and hardware register file
`timescale 1ns/1ps
module hw_side_model #(
  parameter logic [15:0] TBL_BASE = 16'h4000
) (
  // clock
  input wire logic ref_clk,
  // table fetch
  input wire logic tbl_rd_q,
  input wire logic [15:0] tbl_addr_q,
  output logic [63:0] tbl_data,
  // hardware registers
  input wire logic [7:0] sfr_addr,
  output logic [7:0] hw_rdata
);
  logic [15:0] first_addr_q;
  int fetch_cnt_q;
  function automatic logic [63:0] entry(input logic [15:0] idx);
    case (idx)
      // no rights but spans everything, so a careless match would show
      16'h0000: entry = {5'h00, 3'b000, 2'b00, 18'h00000, 18'h3FFFF, 18'h00000};
      16'h0001: entry = {5'h00, 3'b101, 2'b10, 18'h00000, 18'h000FF, 18'h02000};
      16'h0002: entry = {5'h00, 3'b110, 2'b00, 18'h00100, 18'h001FF, 18'h17F00};
      default: entry = 64'h0;
    endcase
  endfunction : entry
  initial
  begin
    tbl_data = 64'h0;
    fetch_cnt_q = 0;
    first_addr_q = 16'h0;
  end
  // data stand only in the cycle after the strobe; otherwise they churn
  always @(posedge ref_clk)
  begin
    if (tbl_rd_q)
    begin
      tbl_data <= entry(tbl_addr_q - TBL_BASE);
      if (fetch_cnt_q == 0)
        first_addr_q <= tbl_addr_q;
      fetch_cnt_q <= fetch_cnt_q + 1;
    end
    else
      tbl_data <= ~tbl_data;
  end
  assign hw_rdata = sfr_addr ^ 8'h3C;
endmodule : hw_side_model

// *** test/tb.sv ***
// self-checking bench for the access guard
`timescale 1ns/1ps
module tb;
  localparam logic [2:0] OP_R = 3'b100;
  localparam logic [2:0] OP_W = 3'b010;
  localparam logic [2:0] OP_X = 3'b001;
  logic ref_clk;
  logic rst;
  logic ce;
  logic boot_flag;
  logic test_flag;
  acc_pkg::mem_op_type cpu_op;
  logic [17:0] cpu_vaddr;
  logic [7:0] cpu_wdata;
  acc_pkg::mem_op_type mem_op_q;
  logic [17:0] mem_addr_q;
  logic [7:0] mem_wdata_q;
  logic fault_q;
  logic busy_q;
  acc_pkg::sfr_req_type sfr;
  logic [7:0] sfr_rdata_q;
  logic hw_rd_q;
  logic hw_wr_q;
  logic [7:0] hw_addr_q;
  logic [7:0] hw_wdata_q;
  logic [7:0] hw_rdata;
  logic tbl_rd_q;
  logic [15:0] tbl_addr_q;
  logic [63:0] tbl_data;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  access_guard DUT (.ref_clk(ref_clk), .rst(rst), .ce(ce), .boot_flag(boot_flag),
    .test_flag(test_flag), .cpu_op(cpu_op), .cpu_vaddr(cpu_vaddr), .cpu_wdata(cpu_wdata),
    .mem_op_q(mem_op_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
    .fault_q(fault_q), .busy_q(busy_q), .sfr(sfr), .sfr_rdata_q(sfr_rdata_q),
    .hw_rd_q(hw_rd_q), .hw_wr_q(hw_wr_q), .hw_addr_q(hw_addr_q), .hw_wdata_q(hw_wdata_q),
    .hw_rdata(hw_rdata), .tbl_rd_q(tbl_rd_q), .tbl_addr_q(tbl_addr_q), .tbl_data(tbl_data));
  hw_side_model far (.ref_clk(ref_clk), .tbl_rd_q(tbl_rd_q), .tbl_addr_q(tbl_addr_q),
    .tbl_data(tbl_data), .sfr_addr(sfr.addr), .hw_rdata(hw_rdata));
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  // the whole run needs well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [7:0] hwv(input logic [7:0] a);
    hwv = a ^ 8'h3C;
  endfunction : hwv
  // one memory request; entered and left just after a rising edge
  task automatic mem(input logic [2:0] op, input logic [17:0] va, input logic ok,
    input logic [17:0] pa);
    cpu_op <= op;
    cpu_vaddr <= va;
    cpu_wdata <= va[7:0] ^ 8'hA5;
    @(posedge ref_clk);
    cpu_op <= 3'b000;
    #1;
    check("mem_op", mem_op_q, ok ? op : 3'b000);
    check("fault", fault_q, !ok);
    if (ok)
      check("mem_addr", mem_addr_q, pa);
    if (ok && op == OP_W)
      check("mem_wdata", mem_wdata_q, va[7:0] ^ 8'hA5);
    @(posedge ref_clk);
  endtask : mem
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic hw_ok);
    sfr <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk);
    sfr <= '0;
    #1;
    check("hw_wr", hw_wr_q, hw_ok);
    if (hw_ok)
      check("hw_addr_data", {hw_addr_q, hw_wdata_q}, {a, d});
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hw_ok);
    sfr <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    sfr <= '0;
    #1;
    check("sfr_rdata", sfr_rdata_q, exp);
    check("hw_rd", hw_rd_q, hw_ok);
    @(posedge ref_clk);
  endtask : rd
  task automatic do_reset;
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : do_reset
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    boot_flag = 1'b0;
    test_flag = 1'b0;
    cpu_op = 3'b000;
    cpu_vaddr = 18'h0;
    cpu_wdata = 8'h0;
    sfr = '0;
    do_reset();
    check("idle_outs", {mem_op_q, fault_q, busy_q, hw_rd_q, hw_wr_q, tbl_rd_q}, 0);
    rd(acc_pkg::PSH, 8'h01, 1'b0);
    rd(acc_pkg::STAT, 8'h03, 1'b0);
    mem(OP_R, 18'h02000, 1'b1, 18'h02000);
    mem(OP_X, 18'h0FFFF, 1'b1, 18'h0FFFF);
    mem(OP_R, 18'h01FFF, 1'b0, 18'h0);
    mem(OP_W, 18'h02000, 1'b0, 18'h0);
    mem(OP_W, 18'h16FFF, 1'b1, 18'h16FFF);
    mem(OP_W, 18'h17000, 1'b0, 18'h0);
    mem(OP_W, 18'h186FF, 1'b1, 18'h186FF);
    mem(OP_R, 18'h18700, 1'b0, 18'h0);
    mem(OP_X, 18'h18000, 1'b0, 18'h0);
    mem(OP_R, 18'h17F80, 1'b0, 18'h0);
    wr(8'h80, 8'h5A, 1'b1);
    wr(acc_pkg::SFR_READ_ONLY, 8'h01, 1'b0);
    rd(acc_pkg::SFR_READ_ONLY, hwv(acc_pkg::SFR_READ_ONLY), 1'b1);
    rd(acc_pkg::SFR_NO_READ, 8'h00, 1'b0);
    boot_flag <= 1'b1;
    @(posedge ref_clk);
    rd(acc_pkg::STAT, 8'h00, 1'b0);
    mem(OP_X, 18'h00100, 1'b1, 18'h00100);
    mem(OP_R, 18'h02000, 1'b0, 18'h0);
    mem(OP_W, 18'h17F7F, 1'b1, 18'h17F7F);
    mem(OP_W, 18'h17F80, 1'b0, 18'h0);
    mem(OP_W, 18'h187FF, 1'b1, 18'h187FF);
    mem(OP_W, 18'h186FF, 1'b0, 18'h0);
    mem(OP_X, 18'h18700, 1'b0, 18'h0);
    test_flag <= 1'b1;
    @(posedge ref_clk);
    rd(acc_pkg::STAT, 8'h01, 1'b0);
    mem(OP_X, 18'h0FFFF, 1'b1, 18'h0FFFF);
    mem(OP_W, 18'h17F80, 1'b1, 18'h17F80);
    mem(OP_W, 18'h10000, 1'b1, 18'h10000);
    mem(OP_R, 18'h18000, 1'b1, 18'h18000);
    mem(OP_X, 18'h18000, 1'b0, 18'h0);
    mem(OP_W, 18'h00000, 1'b0, 18'h0);
    boot_flag <= 1'b0;
    test_flag <= 1'b0;
    @(posedge ref_clk);
    // table walk from word address 0x4000
    wr(acc_pkg::PTR_LO, 8'h00, 1'b0);
    wr(acc_pkg::PTR_HI, 8'h40, 1'b0);
    check("busy", busy_q, 1'b1);
    mem(OP_R, 18'h02000, 1'b0, 18'h0);
    n = 0;
    while (busy_q !== 1'b0 && n < 400)
    begin
      @(posedge ref_clk);
      n++;
    end
    check("walk_done", n < 400, 1'b1);
    check("fetches", far.fetch_cnt_q, 64);
    check("first_fetch", far.first_addr_q, 16'h4000);
    rd(acc_pkg::PTR_HI, 8'h40, 1'b0);
    wr(acc_pkg::PSH, 8'h00, 1'b0);
    rd(acc_pkg::PSH, 8'h00, 1'b0);
    mem(OP_X, 18'h00010, 1'b1, 18'h02010);
    mem(OP_W, 18'h00010, 1'b0, 18'h0);
    mem(OP_R, 18'h00150, 1'b1, 18'h18050);
    mem(OP_X, 18'h00150, 1'b0, 18'h0);
    mem(OP_R, 18'h00300, 1'b0, 18'h0);
    rd(8'h80, hwv(8'h80), 1'b1);
    wr(8'h80, 8'h22, 1'b0);
    rd(acc_pkg::PTR_HI, 8'h00, 1'b0);
    wr(acc_pkg::PTR_HI, 8'h00, 1'b0);
    check("busy_user", busy_q, 1'b0);
    do_reset();
    wr(acc_pkg::FW_LO, 8'h01, 1'b0);
    wr(acc_pkg::FW_HI, 8'h02, 1'b0);
    wr(acc_pkg::XS_LO, 8'h10, 1'b0);
    wr(acc_pkg::PSH, 8'h02, 1'b0);
    rd(acc_pkg::FW_LO, 8'h01, 1'b0);
    rd(8'h80, hwv(8'h80), 1'b1);
    rd(8'h90, 8'h00, 1'b0);
    wr(8'h90, 8'h33, 1'b1);
    wr(8'h80, 8'h33, 1'b0);
    wr(acc_pkg::FW_LO, 8'hFF, 1'b0);
    rd(acc_pkg::FW_LO, 8'h01, 1'b0);
    mem(OP_W, 18'h17000, 1'b1, 18'h17000);
    mem(OP_W, 18'h10000, 1'b0, 18'h0);
    mem(OP_R, 18'h18700, 1'b1, 18'h18700);
    mem(OP_R, 18'h18000, 1'b1, 18'h18000);
    mem(OP_R, 18'h18010, 1'b0, 18'h0);
    final_report();
  end
endmodule : tb
